/* rtl/spss_pkg.sv */
package spss_pkg;

  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          STRAP_SETTLE_NS = 300;
  localparam int          STRAP_SETTLE_CYC =
    ((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int          INSTR_BITS  = 16;
  localparam int          BYTE_BITS   = 8;
  localparam int          RW_POS      = 15;
  localparam int          ADDR_BITS   = 13;

  localparam logic [12:0] CFG_ADDR      = 13'h0000;
  localparam logic [12:0] STD_AREA_LAST = 13'h000f;

  localparam int          CFG_LSB_A   = 1;
  localparam int          CFG_LSB_B   = 6;
  localparam int          CFG_ASC_A   = 2;
  localparam int          CFG_ASC_B   = 5;
  localparam int          CFG_4W_A    = 3;
  localparam int          CFG_4W_B    = 4;
  localparam logic [7:0]  CFG_RESET   = 8'h00;

  localparam logic [4:0]  I2C_ADDR_HI = 5'h15;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_INSTR = 2'b01,
    PH_WRITE = 2'b10,
    PH_READ  = 2'b11
  } spss_phase_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } spss_reg_req_s;

  typedef struct packed {
    logic       locked;
    logic       spi_active;
    logic       i2c_active;
    logic [6:0] i2c_addr;
  } spss_port_sel_s;

endpackage : spss_pkg

/* rtl/spss_spi_slave.sv */
`timescale 1ns/10ps
// Overview of operation
// - Exactly one protocol enabled from strap pins.
// - Chosen protocol stays fixed until reset.
// - Both straps low selects SPI, else I2C.
// - I2C address 10101 plus strap-coded low bits.
// - Capture on SCLK rise, launch on fall.
// - Three-wire uses SDIO both ways; four-wire uses data-out.
// - MSB-first or LSB-first, software programmable.
// - Chip select falling starts a new transfer.
// - No byte count; chip select high ends.
// - Address steps per byte per ascension bits.
// - Data pins released while chip select high.
// - Legacy length bits become address A14, A13.
// - Config register 0x0000 lives in SPI logic.
// - Lowest sixteen addresses keep standard layout.
// - Sixteen-bit instruction: R/W then fifteen address bits.
// - Address bits A14 and A13 forced to zero.
// - Increment toward 0x1FFF or decrement toward 0x0000.
// - MSB first default; bits 1,6 select LSB.
module spss_spi_slave (
  input  wire logic                    i_clock,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_port_select_strap0,
  input  wire logic                    i_port_select_strap1,
  input  wire logic                    i_sclk,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_sdio,
  output logic                         o_sdio_out,
  output logic                         o_sdio_oe,
  output logic                         o_serial_data_out,
  output logic                         o_serial_data_out_oe,
  output spss_pkg::spss_port_sel_s     o_port_sel,
  output logic [7:0]                   o_cfg,
  output spss_pkg::spss_reg_req_s      o_reg_req,
  input  wire logic [7:0]              i_reg_rdata
);
  import spss_pkg::*;

  function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic b,
                                           input logic lsb_first);
    shift_in = lsb_first ? {b, sh[15:1]} : {sh[14:0], b};
  endfunction : shift_in

  function automatic logic [7:0] take_byte(input logic [15:0] sh, input logic lsb_first);
    take_byte = lsb_first ? sh[15:8] : sh[7:0];
  endfunction : take_byte

  function automatic logic [12:0] step_addr(input logic [12:0] a, input logic up);
    step_addr = up ? a + 13'h0001 : a - 13'h0001;
  endfunction : step_addr

  logic           sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic           cs_s1_reg, cs_s2_reg;
  logic           sdio_s1_reg, sdio_s2_reg;
  logic           st0_s1_reg, st0_s2_reg, st1_s1_reg, st1_s2_reg;
  logic [3:0]     settle_cnt_reg;
  spss_port_sel_s port_sel_reg;
  spss_phase_e    phase_reg;
  logic [3:0]     bit_cnt_reg;
  logic [15:0]    shift_reg;
  logic [15:0]    shift_next;
  logic [12:0]    addr_reg;
  logic [7:0]     cfg_reg;
  logic [7:0]     tx_shift_reg;
  logic           tx_bit_reg;
  logic           tx_en_reg;
  spss_reg_req_s  req_reg;
  logic           sclk_rise, sclk_fall, cs_active;
  logic           lsb_first, ascend, four_wire;
  logic           instr_done, byte_done;
  logic [7:0]     rx_byte;

  // Every pin from the host or the board crosses two flops before any logic sees it.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      sdio_s1_reg <= 1'b0;
      sdio_s2_reg <= 1'b0;
      st0_s1_reg  <= 1'b0;
      st0_s2_reg  <= 1'b0;
      st1_s1_reg  <= 1'b0;
      st1_s2_reg  <= 1'b0;
    end else begin
      sclk_s1_reg <= i_sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg   <= i_cs_n;
      cs_s2_reg   <= cs_s1_reg;
      sdio_s1_reg <= i_sdio;
      sdio_s2_reg <= sdio_s1_reg;
      st0_s1_reg  <= i_port_select_strap0;
      st0_s2_reg  <= st0_s1_reg;
      st1_s1_reg  <= i_port_select_strap1;
      st1_s2_reg  <= st1_s1_reg;
    end
  end

  // Straps are caught once, a few cycles after reset release, and then frozen.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      settle_cnt_reg <= 4'h0;
      port_sel_reg   <= '0;
    end else if (!port_sel_reg.locked) begin
      settle_cnt_reg <= settle_cnt_reg + 4'h1;
      if (settle_cnt_reg == 4'(STRAP_SETTLE_CYC - 1)) begin
        port_sel_reg.locked     <= 1'b1;
        port_sel_reg.spi_active <= ~st1_s2_reg & ~st0_s2_reg;
        port_sel_reg.i2c_active <= st1_s2_reg | st0_s2_reg;
        port_sel_reg.i2c_addr   <= {I2C_ADDR_HI, st1_s2_reg & st0_s2_reg,
                                    st1_s2_reg & ~st0_s2_reg};
      end
    end
  end

  assign sclk_rise  = sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall  = ~sclk_s2_reg & sclk_s3_reg;
  assign cs_active  = ~cs_s2_reg & port_sel_reg.locked & port_sel_reg.spi_active;
  assign lsb_first  = cfg_reg[CFG_LSB_A] | cfg_reg[CFG_LSB_B];
  assign ascend     = cfg_reg[CFG_ASC_A] | cfg_reg[CFG_ASC_B];
  assign four_wire  = cfg_reg[CFG_4W_A] | cfg_reg[CFG_4W_B];
  assign shift_next = shift_in(shift_reg, sdio_s2_reg, lsb_first);
  assign instr_done = sclk_rise && phase_reg == PH_INSTR &&
                      bit_cnt_reg == 4'(INSTR_BITS - 1);
  assign byte_done  = sclk_rise && (phase_reg == PH_WRITE || phase_reg == PH_READ) &&
                      bit_cnt_reg == 4'(BYTE_BITS - 1);
  assign rx_byte    = take_byte(shift_next, lsb_first);

  // Transfer sequencing: instruction, then an open-ended run of payload bytes.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_reg   <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 16'h0000;
      addr_reg    <= 13'h0000;
    end else if (!cs_active) begin
      phase_reg   <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          phase_reg   <= PH_INSTR;
          bit_cnt_reg <= 4'h0;
        end
        PH_INSTR: begin
          if (sclk_rise) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (instr_done) begin
              bit_cnt_reg <= 4'h0;
              phase_reg   <= shift_next[RW_POS] ? PH_READ : PH_WRITE;
              // A14 and A13 are dropped; the old length bits land in A14..A13.
              addr_reg    <= shift_next[ADDR_BITS-1:0];
            end
          end
        end
        default: begin
          if (sclk_rise) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (byte_done) begin
              bit_cnt_reg <= 4'h0;
              // Natural 13-bit wrap carries the walk past 0x1FFF to 0x0000 and past 0x0000 to 0x1FFF.
              addr_reg    <= step_addr(addr_reg, ascend);
            end
          end
        end
      endcase
    end
  end

  // The port configuration register is private to this block.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_reg <= CFG_RESET;
    end else if (cs_active && byte_done && phase_reg == PH_WRITE && addr_reg == CFG_ADDR) begin
      cfg_reg <= rx_byte;
    end
  end

  // Requests to the main map; writes to address 0 never leave this block, reads of it still strobe out.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_reg <= '0;
    end else begin
      req_reg.wr <= 1'b0;
      req_reg.rd <= 1'b0;
      if (cs_active && byte_done && phase_reg == PH_WRITE && addr_reg != CFG_ADDR) begin
        req_reg.wr    <= 1'b1;
        req_reg.addr  <= addr_reg;
        req_reg.wdata <= rx_byte;
      end
      if (cs_active && ((instr_done && shift_next[RW_POS]) ||
                        (byte_done && phase_reg == PH_READ))) begin
        req_reg.rd   <= 1'b1;
        req_reg.addr <= (phase_reg == PH_INSTR) ? shift_next[ADDR_BITS-1:0]
                                                : step_addr(addr_reg, ascend);
      end
    end
  end

  // Read data is loaded while the read strobe stands; the next falling edge comes later,
  // so the serial clock half period must span at least two system clocks.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_shift_reg <= 8'h00;
      tx_bit_reg   <= 1'b0;
      tx_en_reg    <= 1'b0;
    end else if (!cs_active || phase_reg != PH_READ) begin
      tx_en_reg    <= 1'b0;
      if (req_reg.rd) begin
        tx_shift_reg <= (req_reg.addr == CFG_ADDR) ? cfg_reg : i_reg_rdata;
      end
    end else if (req_reg.rd) begin
      tx_shift_reg <= (req_reg.addr == CFG_ADDR) ? cfg_reg : i_reg_rdata;
    end else if (sclk_fall) begin
      tx_en_reg    <= 1'b1;
      tx_bit_reg   <= lsb_first ? tx_shift_reg[0] : tx_shift_reg[7];
      tx_shift_reg <= lsb_first ? {1'b0, tx_shift_reg[7:1]} : {tx_shift_reg[6:0], 1'b0};
    end
  end

  assign o_sdio_out           = tx_bit_reg;
  assign o_serial_data_out    = tx_bit_reg;
  assign o_sdio_oe            = tx_en_reg & ~four_wire;
  assign o_serial_data_out_oe = tx_en_reg & four_wire;
  assign o_port_sel           = port_sel_reg;
  assign o_cfg                = cfg_reg;
  assign o_reg_req            = req_reg;

endmodule : spss_spi_slave

/* bench/spss_spi_slave_monitor.sv */
`timescale 1ns/10ps
module spss_spi_slave_monitor
  import spss_pkg::*;
(
  input wire logic                     i_clock,
  input wire logic                     i_sys_rst,
  input wire logic                     i_port_select_strap0,
  input wire logic                     i_port_select_strap1,
  input wire logic                     i_sclk,
  input wire logic                     i_cs_n,
  input wire logic                     o_sdio_out,
  input wire logic                     o_sdio_oe,
  input wire logic                     o_serial_data_out_oe,
  input wire spss_pkg::spss_port_sel_s o_port_sel,
  input wire logic [7:0]               o_cfg,
  input wire spss_pkg::spss_reg_req_s  o_reg_req
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_one_port: assert property (
    o_port_sel.locked |-> o_port_sel.spi_active ^ o_port_sel.i2c_active)
    else $error("port select not exclusive");
  a_port_fixed: assert property ($past(o_port_sel.locked) |-> $stable(o_port_sel))
    else $error("port select changed after lock");
  a_spi_strap: assert property (
    $rose(o_port_sel.locked) |->
    o_port_sel.spi_active == !(i_port_select_strap0 || i_port_select_strap1))
    else $error("wrong protocol for straps");
  a_i2c_addr: assert property (
    o_port_sel.i2c_active |->
    o_port_sel.i2c_addr[6:2] == I2C_ADDR_HI && o_port_sel.i2c_addr[1:0] != 2'h3)
    else $error("bad i2c address");
  a_launch_fall: assert property (
    (o_sdio_oe || o_serial_data_out_oe) && $changed(o_sdio_out) |-> !i_sclk)
    else $error("read bit changed while clock high");
  a_oe_onehot: assert property (!(o_sdio_oe && o_serial_data_out_oe))
    else $error("both data pins driven");
  a_sdio_mode: assert property (o_sdio_oe |-> !(o_cfg[3] || o_cfg[4]))
    else $error("data pin driven in four wire mode");
  a_dout_mode: assert property (o_serial_data_out_oe |-> o_cfg[3] || o_cfg[4])
    else $error("data out driven in three wire mode");
  a_idle_float: assert property (
    i_cs_n [*4] |-> !(o_sdio_oe || o_serial_data_out_oe))
    else $error("pin driven while deselected");
  a_cfg_local: assert property (o_reg_req.wr |-> o_reg_req.addr != CFG_ADDR)
    else $error("config write reached main map");
  a_spi_gated: assert property (
    !o_port_sel.spi_active |-> !(o_reg_req.wr || o_reg_req.rd))
    else $error("request without spi selected");
  a_write_quiet: assert property (
    o_reg_req.wr |-> !(o_sdio_oe || o_serial_data_out_oe))
    else $error("data pin driven during write");
  c_write: cover property (o_reg_req.wr);
  c_read: cover property (o_reg_req.rd);
  c_four_wire: cover property (o_serial_data_out_oe);
endmodule : spss_spi_slave_monitor
bind spss_spi_slave spss_spi_slave_monitor i_mon (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_port_select_strap0(i_port_select_strap0), .i_port_select_strap1(i_port_select_strap1),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_sdio_out(o_sdio_out), .o_sdio_oe(o_sdio_oe),
  .o_serial_data_out_oe(o_serial_data_out_oe), .o_port_sel(o_port_sel), .o_cfg(o_cfg),
  .o_reg_req(o_reg_req));

/* bench/spss_host.sv */
`timescale 1ns/10ps
module spss_host (
  input  wire logic i_clock,
  input  wire logic i_dev_oe,
  input  wire logic i_dev_out,
  input  wire logic i_dout_oe,
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdio
);
  logic       drv_en = 1'b0;
  logic       drv_bit = 1'b0;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  // A released wire shows the inverse of its last value so stale data cannot pass.
  assign o_sdio = i_dev_oe ? i_dev_out : (drv_en ? drv_bit : ~drv_bit);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  task automatic bits(input logic [15:0] w, input int n, input bit lsb, input bit rd,
                      output logic [15:0] r);
    int k;
    r = '0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      drv_en = !rd;
      drv_bit = w[k];
      repeat (4) @(negedge i_clock);
      o_sclk = 1'b1;
      r[k] = i_dev_oe ? i_dev_out : (i_dout_oe ? i_dout : 1'bx);
      repeat (4) @(negedge i_clock);
      o_sclk = 1'b0;
    end
  endtask : bits
  task automatic frame(input logic rw, input logic [12:0] a, input int n, input bit lsb);
    logic [15:0] r;
    rq.delete();
    @(negedge i_clock);
    o_cs_n = 1'b0;
    bits({rw, 2'h3, a}, 16, lsb, 1'b0, r);
    for (int j = 0; j < n; j++) begin
      bits(rw ? 16'h0000 : {8'h00, wq[j]}, 8, lsb, rw, r);
      rq.push_back(r[7:0]);
    end
    repeat (4) @(negedge i_clock);
    o_cs_n = 1'b1;
    drv_en = 1'b0;
    repeat (6) @(negedge i_clock);
  endtask : frame
endmodule : spss_host

/* bench/test_serial_port_select_spi_slave.sv */
`timescale 1ns/10ps
module test_serial_port_select_spi_slave;
  import spss_pkg::*;
  logic clk = 1'b0, rst = 1'b1, s0 = 1'b0, s1 = 1'b0;
  logic sclk, cs_n, sdio, so, so_oe, dout, dout_oe;
  logic [7:0] cfg;
  spss_port_sel_s psel;
  spss_reg_req_s req;
  logic [20:0] wlog[$];
  logic [20:0] seen_w, exp_w;
  int failures = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  spss_spi_slave i_dut (.i_clock(clk), .i_sys_rst(rst), .i_port_select_strap0(s0),
    .i_port_select_strap1(s1), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio(sdio), .o_sdio_out(so),
    .o_sdio_oe(so_oe), .o_serial_data_out(dout), .o_serial_data_out_oe(dout_oe),
    .o_port_sel(psel), .o_cfg(cfg), .o_reg_req(req), .i_reg_rdata(req.addr[7:0] ^ 8'h5a));
  spss_host i_host (.i_clock(clk), .i_dev_oe(so_oe), .i_dev_out(so), .i_dout_oe(dout_oe),
    .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));
  always @(posedge clk) if (req.wr === 1'b1) wlog.push_back({req.addr, req.wdata});
  task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic restart(input logic [1:0] s);
    @(negedge clk);
    rst = 1'b1;
    {s1, s0} = s;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask : restart
  initial begin
    for (int s = 1; s < 4; s++) begin
      restart(2'(s));
      seen_w = 21'({psel.locked, psel.spi_active, psel.i2c_active, psel.i2c_addr});
      exp_w  = 21'({3'b101, I2C_ADDR_HI, 2'(s - 1)});
      check("i2c sel", seen_w, exp_w);
      i_host.wq = '{8'h11};
      i_host.frame(1'b0, 13'h0003, 1, 1'b0);
      check("i2c blocks spi", 21'(wlog.size()), 21'h0);
    end
    $display("test strap select done");
    restart(2'h0);
    check("spi sel", 21'({psel.locked, psel.spi_active, psel.i2c_active}), 21'h6);
    i_host.wq = '{8'ha1, 8'hb2, 8'hc3};
    i_host.frame(1'b0, 13'h1234, 3, 1'b0);
    check("wr count", 21'(wlog.size()), 21'h3);
    for (int j = 0; j < 3; j++) begin
      exp_w = {13'h1234 - 13'(j), i_host.wq[j]};
      check("wr msb", wlog[j], exp_w);
    end
    i_host.frame(1'b1, 13'h0002, 3, 1'b0);
    for (int j = 0; j < 3; j++) begin
      exp_w = 21'(j == 2 ? CFG_RESET : 8'h5a ^ 8'(2 - j));
      check("rd msb", 21'(i_host.rq[j]), exp_w);
    end
    // The top of the standard area must still reach the main map.
    wlog.delete();
    i_host.wq = '{8'h0f};
    i_host.frame(1'b0, STD_AREA_LAST, 1, 1'b0);
    check("std wr count", 21'(wlog.size()), 21'h1);
    check("std wr", wlog[0], {STD_AREA_LAST, 8'h0f});
    $display("test msb stream done");
    wlog.delete();
    i_host.wq = '{8'h66};
    i_host.frame(1'b0, 13'h0000, 1, 1'b0);
    check("cfg", 21'(cfg), 21'h66);
    i_host.wq = '{8'h3c, 8'hc5};
    i_host.frame(1'b0, 13'h0010, 2, 1'b1);
    check("wr lsb count", 21'(wlog.size()), 21'h2);
    for (int j = 0; j < 2; j++) begin
      exp_w = {13'h0010 + 13'(j), i_host.wq[j]};
      check("wr lsb", wlog[j], exp_w);
    end
    $display("test lsb stream done");
    i_host.wq = '{8'h7e};
    i_host.frame(1'b0, 13'h0000, 1, 1'b1);
    i_host.frame(1'b1, 13'h0005, 2, 1'b1);
    for (int j = 0; j < 2; j++) begin
      exp_w = 21'(8'h5a ^ 8'(5 + j));
      check("rd 4 wire", 21'(i_host.rq[j]), exp_w);
    end
    $display("test four wire done");
    end_of_test();
  end
  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule : test_serial_port_select_spi_slave
